/* File: include/dkc_regs.vh */
// Purpose: Constants of the disk controller host register block
// Assumes: 32-bit AHB-Lite, word aligned registers
// Notes: Included by the block only
// Overview of operation
// R1 - Three host registers: command, data, address; the block also has interrupt status and interrupt mask registers
// R2 - Internal sector buffer of 64 16-bit words
// R3 - Host fills buffer before write sector command
// R4 - Read: disk to buffer, host empties buffer
// R5 - Completion loads status word into data port
// R6 - Host loads track/sector before sector commands
// R7 - Bit 15 fault flag, cleared on new command
// R8 - Bit 7 done; done and enable request interrupt
// R9 - Bit 6 interrupt enable, cleared by reset
// R10 - Bit 4 selects drive 0 or 1
// R11 - Bits 3-1 write-only eight-way function code
// R12 - Trigger bit starts selected function, drive
// R13 - Unused and write-only bits read zero
// R14 - Done cleared at start, set at finish
// R15 - Sector not found sets fault and done
// R16 - Automatic initialize at power-up, host waits
`ifndef DKC_REGS_VH
`define DKC_REGS_VH

// Register byte offsets
`define DKC_OFS_CMD 8'h00
`define DKC_OFS_DATA 8'h04
`define DKC_OFS_TSA 8'h08
`define DKC_OFS_IST 8'h0C
`define DKC_OFS_IMSK 8'h10

// Command/status field positions
`define DKC_BIT_GO 0
`define DKC_BIT_UNIT 4
`define DKC_BIT_IE 6
`define DKC_BIT_DONE 7
`define DKC_BIT_ERR 15

// Function codes
`define DKC_FN_FILL 3'h0
`define DKC_FN_EMPTY 3'h1
`define DKC_FN_WRSEC 3'h2
`define DKC_FN_RDSEC 3'h3
`define DKC_FN_INIT 3'h4
`define DKC_FN_RDSTAT 3'h5
`define DKC_FN_WRDEL 3'h6
`define DKC_FN_RESTORE 3'h7

// Interrupt status bits
`define DKC_IST_DONE 0
`define DKC_IST_ERR 1

// Buffer geometry and reset values
`define DKC_BUF_WORDS 64
`define DKC_BUF_LAST 6'h3F
`define DKC_RST_TSA 16'h0000
`define DKC_RST_STAT 16'h0000
`define DKC_RST_IMSK 2'h0

`endif

/* File: rtl/dkc_host_regs.v */
// Purpose: Host register interface of a two-drive floppy controller
// Assumes: Drive sequencer is logic on hclk; AHB-Lite single word access
// Notes: Each access has one wait state; hrdata comes from a flop
//
// The register offsets and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`include "dkc_regs.vh"

module dkc_host_regs (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [7:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    output reg irq,
    output reg cmd_start,
    output reg [2:0] cmd_func,
    output reg cmd_unit,
    output reg [15:0] cmd_track_sector,
    input wire drv_done,
    input wire drv_err,
    input wire [15:0] drv_status,
    input wire drv_buf_we,
    input wire [5:0] drv_buf_addr,
    input wire [15:0] drv_buf_wdata,
    output reg [15:0] drv_buf_rdata
);

////////////////////////////////////////////////////////////////////////////
// States
localparam ST_IDLE = 2'b00;
localparam ST_FILL = 2'b01;
localparam ST_EMPTY = 2'b10;
localparam ST_DRIVE = 2'b11;

// R2 - sector buffer
reg [15:0] buf_mem [0:`DKC_BUF_WORDS-1];

reg [1:0] state_q;
reg [5:0] ptr_q;
reg pend_q;
reg pend_wr_q;
reg [7:0] pend_addr_q;
reg err_q;
reg done_q;
reg ie_q;
reg unit_q;
reg [15:0] stat_q;
reg [1:0] ist_q;
reg [1:0] imsk_q;
reg boot_q;

wire wr_go;
wire rd_go;
wire cmd_wr;
wire data_wr;
wire data_rd;
wire go_bit;
wire [2:0] fn_wr;
wire [1:0] ist_set;
wire done_evt;
wire err_evt;
wire [15:0] cmd_rd;

function match;
    input [7:0] a;
    input [7:0] ofs;
    begin
        match = (a[7:2] == ofs[7:2]);
    end
endfunction

function at_last;
    input [5:0] p;
    begin
        at_last = (p == `DKC_BUF_LAST);
    end
endfunction

function [5:0] next_ptr;
    input [5:0] p;
    begin
        next_ptr = p + 6'h01;
    end
endfunction

////////////////////////////////////////////////////////////////////////////
// Bus decode, data phase of the pending access
assign wr_go = pend_q & pend_wr_q;
assign rd_go = pend_q & ~pend_wr_q;
assign cmd_wr = wr_go & match(pend_addr_q, `DKC_OFS_CMD);
assign data_wr = wr_go & match(pend_addr_q, `DKC_OFS_DATA);
assign data_rd = rd_go & match(pend_addr_q, `DKC_OFS_DATA);
assign go_bit = hwdata[`DKC_BIT_GO];
assign fn_wr = hwdata[3:1];

// R13 - unused and write-only read zero
assign cmd_rd = {err_q, 7'h00, done_q, ie_q, 1'b0, unit_q, 4'h0};

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        pend_q <= 1'b0;
        pend_wr_q <= 1'b0;
        pend_addr_q <= 8'h00;
        hreadyout <= 1'b1;
        hresp <= 1'b0;
    end else if (pend_q) begin
        pend_q <= 1'b0;
        hreadyout <= 1'b1;
    end else if (hsel & hready & htrans[1]) begin
        pend_q <= 1'b1;
        pend_wr_q <= hwrite;
        pend_addr_q <= haddr;
        hreadyout <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////
// R1 - read data mux
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        hrdata <= 32'h0000_0000;
    end else if (rd_go) begin
        if (match(pend_addr_q, `DKC_OFS_CMD)) begin
            hrdata <= {16'h0000, cmd_rd};
        end else if (match(pend_addr_q, `DKC_OFS_DATA)) begin
            // R4 - buffered words during empty
            if (state_q == ST_EMPTY) begin
                hrdata <= {16'h0000, buf_mem[ptr_q]};
            end else begin
                hrdata <= {16'h0000, stat_q};
            end
        end else if (match(pend_addr_q, `DKC_OFS_TSA)) begin
            hrdata <= {16'h0000, cmd_track_sector};
        end else if (match(pend_addr_q, `DKC_OFS_IST)) begin
            hrdata <= {30'h0000_0000, ist_q};
        end else if (match(pend_addr_q, `DKC_OFS_IMSK)) begin
            hrdata <= {30'h0000_0000, imsk_q};
        end else begin
            hrdata <= 32'h0000_0000;
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// Sector buffer ports
always @(posedge hclk) begin
    if (data_wr && state_q == ST_FILL) begin
        buf_mem[ptr_q] <= hwdata[15:0];
    end else if (drv_buf_we && state_q == ST_DRIVE) begin
        buf_mem[drv_buf_addr] <= drv_buf_wdata;
    end
end

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        drv_buf_rdata <= 16'h0000;
    end else begin
        drv_buf_rdata <= buf_mem[drv_buf_addr];
    end
end

////////////////////////////////////////////////////////////////////////////
// Host settable fields
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        // R9 - enable cleared by reset
        ie_q <= 1'b0;
        unit_q <= 1'b0;
        cmd_track_sector <= `DKC_RST_TSA;
        imsk_q <= `DKC_RST_IMSK;
    end else if (wr_go) begin
        if (match(pend_addr_q, `DKC_OFS_CMD)) begin
            ie_q <= hwdata[`DKC_BIT_IE];
            // R10 - drive select bit
            unit_q <= hwdata[`DKC_BIT_UNIT];
        end
        // R6 - address held for sector commands
        if (match(pend_addr_q, `DKC_OFS_TSA)) begin
            cmd_track_sector <= hwdata[15:0];
        end
        if (match(pend_addr_q, `DKC_OFS_IMSK)) begin
            imsk_q <= hwdata[1:0];
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// Function sequencer
assign done_evt = (state_q == ST_FILL && data_wr && at_last(ptr_q))
    || (state_q == ST_EMPTY && data_rd && at_last(ptr_q))
    || (state_q == ST_DRIVE && drv_done);
assign err_evt = state_q == ST_DRIVE && drv_done && drv_err;

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        state_q <= ST_IDLE;
        ptr_q <= 6'h00;
        err_q <= 1'b0;
        done_q <= 1'b0;
        stat_q <= `DKC_RST_STAT;
        cmd_start <= 1'b0;
        cmd_func <= `DKC_FN_INIT;
        cmd_unit <= 1'b0;
        boot_q <= 1'b1;
    end else begin
        cmd_start <= 1'b0;
        boot_q <= 1'b0;
        case (state_q)
            ST_IDLE: begin
                if (boot_q) begin
                    // R16 - power-up initialize
                    state_q <= ST_DRIVE;
                    cmd_start <= 1'b1;
                    cmd_func <= `DKC_FN_INIT;
                    cmd_unit <= 1'b0;
                end else if (cmd_wr && go_bit) begin
                    // R12 - trigger starts function
                    // R7 - fault cleared on new command
                    err_q <= 1'b0;
                    // R14 - done cleared at start
                    done_q <= 1'b0;
                    ptr_q <= 6'h00;
                    // R11 - function code decode
                    case (fn_wr)
                        `DKC_FN_FILL: begin
                            // R3 - host loads buffer
                            state_q <= ST_FILL;
                        end
                        `DKC_FN_EMPTY: begin
                            state_q <= ST_EMPTY;
                        end
                        default: begin
                            state_q <= ST_DRIVE;
                            cmd_start <= 1'b1;
                            cmd_func <= fn_wr;
                            cmd_unit <= hwdata[`DKC_BIT_UNIT];
                        end
                    endcase
                end
            end
            ST_FILL: begin
                if (data_wr) begin
                    ptr_q <= next_ptr(ptr_q);
                    if (at_last(ptr_q)) begin
                        done_q <= 1'b1;
                        state_q <= ST_IDLE;
                    end
                end
            end
            ST_EMPTY: begin
                if (data_rd) begin
                    ptr_q <= next_ptr(ptr_q);
                    if (at_last(ptr_q)) begin
                        done_q <= 1'b1;
                        state_q <= ST_IDLE;
                    end
                end
            end
            ST_DRIVE: begin
                if (drv_done) begin
                    // R14 - done at finish
                    done_q <= 1'b1;
                    // R15 - not found sets fault
                    err_q <= drv_err;
                    // R5 - status word to data port
                    stat_q <= drv_status;
                    state_q <= ST_IDLE;
                end
            end
            default: begin
                state_q <= ST_IDLE;
            end
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////
// Sticky interrupt status, set wins over clear
assign ist_set[`DKC_IST_DONE] = done_evt;
assign ist_set[`DKC_IST_ERR] = err_evt;

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        ist_q <= 2'h0;
        irq <= 1'b0;
    end else begin
        if (wr_go && match(pend_addr_q, `DKC_OFS_IST)) begin
            ist_q <= (ist_q & ~hwdata[1:0]) | ist_set;
        end else begin
            ist_q <= ist_q | ist_set;
        end
        // R8 - done and enable request
        irq <= (done_q & ie_q) | (|(ist_q & imsk_q));
    end
end

endmodule

/* File: tb/dkc_host_regs_properties.sv */
// Purpose: Bus and command checks
// Assumes: Bound to the host register block
// Notes: Ports only
`timescale 1ns/1ps
module dkc_chk (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [7:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire [31:0] hrdata,
    input wire hreadyout,
    input wire hresp,
    input wire irq,
    input wire cmd_start,
    input wire [2:0] cmd_func,
    input wire cmd_unit
);
    wire tk = hsel & hready & htrans[1] & hreadyout;
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    sequence s_rd;
        tk && !hwrite && haddr == 8'h00 ##1 !hreadyout ##1 hreadyout;
    endsequence
    property p_wait;
        tk |=> !hreadyout ##1 hreadyout;
    endproperty
    a_wait: assert property (p_wait) else $error("wait");
    property p_okay;
        !hresp;
    endproperty
    a_okay: assert property (p_okay) else $error("resp");
    property p_hold;
        $changed(hrdata) |-> $past(tk && !hwrite, 2);
    endproperty
    a_hold: assert property (p_hold) else $error("rdata");
    property p_zero;
        s_rd |-> hrdata[31:16] == 0 && hrdata[14:8] == 0 &&
            !hrdata[5] && hrdata[3:0] == 0;
    endproperty
    a_zero: assert property (p_zero) else $error("unused");
    property p_err;
        s_rd ##0 hrdata[15] |-> hrdata[7];
    endproperty
    a_err: assert property (p_err) else $error("err");
    property p_irq;
        s_rd ##0 (hrdata[7] && hrdata[6]) |-> ##[0:2] irq;
    endproperty
    a_irq: assert property (p_irq) else $error("irq");
    property p_pulse;
        cmd_start |=> !cmd_start;
    endproperty
    a_pulse: assert property (p_pulse) else $error("start");
    property p_func;
        $changed(cmd_func) || $changed(cmd_unit) |-> cmd_start;
    endproperty
    a_func: assert property (p_func) else $error("func");
endmodule
bind dkc_host_regs dkc_chk u_chk (.*);

/* File: tb/dkc_drive_model.sv */
// Purpose: Drive sequencer model
// Assumes: Same clock as the block
// Notes: Fixed run time, failure on request
`timescale 1ns/1ps
module dkc_drive_model (
    input wire clk,
    input wire rst_n,
    input wire cmd_start,
    input wire [2:0] cmd_func,
    input wire [15:0] cmd_track_sector,
    input wire fail,
    output reg drv_done,
    output reg drv_err,
    output reg [15:0] drv_status,
    output reg drv_buf_we,
    output reg [5:0] drv_buf_addr,
    output reg [15:0] drv_buf_wdata
);
    reg busy_q;
    reg [6:0] cnt_q;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_q <= 1'b0;
            cnt_q <= 7'h00;
        end else if (cmd_start && cmd_func[2:1] != 2'h0) begin
            busy_q <= 1'b1;
            cnt_q <= 7'h00;
        end else if (busy_q) begin
            cnt_q <= cnt_q + 7'h01;
            busy_q <= cnt_q != 7'h45;
        end
    end
    always @* begin
        drv_buf_we = busy_q && cmd_func == 3'h3 && !cnt_q[6];
        drv_buf_addr = cnt_q[5:0];
        drv_buf_wdata = cmd_track_sector ^ {10'h000, cnt_q[5:0]};
        drv_done = busy_q && cnt_q == 7'h45;
        drv_err = drv_done ? fail : ~fail;
        drv_status = cmd_track_sector ^ {13'h0000, cmd_func};
        if (!drv_done)
            drv_status = ~drv_status;
    end
endmodule

/* File: tb/tb_dkc_host_regs.sv */
// Purpose: Self-checking bench of the host registers
// Assumes: Drive model answers every start
// Notes: Random data from an LFSR seeded with 22
`timescale 1ns/1ps
module tb_dkc_host_regs;
    reg hclk = 1'b0;
    reg hresetn = 1'b0;
    reg hsel = 1'b0;
    reg [7:0] haddr = 8'h00;
    reg [1:0] htrans = 2'h0;
    reg hwrite = 1'b0;
    reg [31:0] hwdata = 32'h0;
    reg fail = 1'b0;
    wire hready, irq, cmd_start, cmd_unit, drv_done, drv_err, drv_buf_we;
    wire [31:0] hrdata;
    wire [2:0] cmd_func;
    wire [15:0] tsa, drv_status, drv_buf_wdata, drv_buf_rdata;
    wire [5:0] drv_buf_addr;
    integer mismatches = 0;
    integer compares = 0;
    integer i, f, n;
    reg [15:0] rnd = 16'h0016;
    reg [15:0] bm [0:63];
    reg [31:0] v;
    always #12.5 hclk = ~hclk;
    dkc_host_regs uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hready), .hresp(), .irq(irq), .cmd_start(cmd_start),
        .cmd_func(cmd_func), .cmd_unit(cmd_unit), .cmd_track_sector(tsa),
        .drv_done(drv_done), .drv_err(drv_err), .drv_status(drv_status),
        .drv_buf_we(drv_buf_we), .drv_buf_addr(drv_buf_addr),
        .drv_buf_wdata(drv_buf_wdata), .drv_buf_rdata(drv_buf_rdata));
    dkc_drive_model u_drv (.clk(hclk), .rst_n(hresetn),
        .cmd_start(cmd_start), .cmd_func(cmd_func), .cmd_track_sector(tsa),
        .fail(fail), .drv_done(drv_done), .drv_err(drv_err),
        .drv_status(drv_status), .drv_buf_we(drv_buf_we),
        .drv_buf_addr(drv_buf_addr), .drv_buf_wdata(drv_buf_wdata));
    function [15:0] nxt(input [15:0] s);
        nxt = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task chk(input [31:0] got, input [31:0] exp);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                mismatches = mismatches + 1;
                $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task xf(input [7:0] a, input w, input [31:0] d);
        begin
            @(posedge hclk);
            haddr <= a;
            hwrite <= w;
            hsel <= 1'b1;
            htrans <= 2'h2;
            @(posedge hclk);
            while (!hready) @(posedge hclk);
            htrans <= 2'h0;
            hwdata <= d;
            @(posedge hclk);
            while (!hready) @(posedge hclk);
            v = hrdata;
        end
    endtask
    task wait_done;
        begin
            v = 32'h0;
            for (n = 0; n < 300 && !v[7]; n = n + 1)
                xf(8'h00, 1'b0, 32'h0);
        end
    endtask
    task conclude;
        begin
            $display("compares %0d mismatches %0d", compares, mismatches);
            if (mismatches == 0 && compares > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    initial begin
        #2000000;
        mismatches = mismatches + 1;
        conclude;
    end
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        wait_done;
        chk(v, 32'h80);
        xf(8'h14, 1'b1, 32'hFFFF_FFFF);
        xf(8'h14, 1'b0, 32'h0);
        chk(v, 32'h0);
        xf(8'h00, 1'b1, 32'hFFFF_FFFE);
        xf(8'h00, 1'b0, 32'h0);
        chk(v, 32'hD0);
        chk(irq, 1'b1);
        xf(8'h00, 1'b1, 32'h0);
        xf(8'h08, 1'b0, 32'h0);
        chk(irq, 1'b0);
        $display("registers done");
        xf(8'h00, 1'b1, 32'h1);
        xf(8'h00, 1'b0, 32'h0);
        chk(v, 32'h0);
        for (i = 0; i < 64; i = i + 1) begin
            rnd = nxt(rnd);
            bm[i] = rnd;
            xf(8'h04, 1'b1, {16'h0, rnd});
        end
        xf(8'h00, 1'b0, 32'h0);
        chk(v, 32'h80);
        xf(8'h10, 1'b1, 32'h3);
        for (f = 2; f < 8; f = f + 1) begin
            rnd = nxt(rnd);
            fail <= f == 2;
            xf(8'h08, 1'b1, {16'h0, rnd});
            xf(8'h00, 1'b1, {25'h0, 2'h2, f[0], f[2:0], 1'b1});
            chk({cmd_unit, cmd_func}, {f[0], f[2:0]});
            wait_done;
            chk(v, {16'h0, f == 2, 7'h0, 3'h6, f[0], 4'h0});
            chk(irq, 1'b1);
            xf(8'h04, 1'b0, 32'h0);
            chk(v, {16'h0, rnd ^ f[15:0]});
            if (f == 3)
                for (i = 0; i < 64; i = i + 1)
                    bm[i] = rnd ^ i[15:0];
        end
        xf(8'h00, 1'b1, 32'h0);
        xf(8'h0C, 1'b0, 32'h0);
        chk(v, 32'h3);
        xf(8'h0C, 1'b1, 32'h3);
        xf(8'h0C, 1'b0, 32'h0);
        chk(v, 32'h0);
        chk(irq, 1'b0);
        $display("functions done");
        xf(8'h00, 1'b1, 32'h3);
        for (i = 0; i < 64; i = i + 1) begin
            xf(8'h04, 1'b0, 32'h0);
            chk(v, {16'h0, bm[i]});
        end
        xf(8'h00, 1'b0, 32'h0);
        chk(v, 32'h80);
        chk(drv_buf_rdata, {16'h0, bm[drv_buf_addr]});
        $display("buffer done");
        conclude;
    end
endmodule
